/* File: hw/sirc_pkg.sv */
// Shared constants and types for the SPI port with interrupt, buffer and reset control
package sirc_pkg;

    // Register byte offsets
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STAT   = 4'h4;
    localparam logic [3:0] ADDR_DATA   = 4'h8;

    // Control register fields
    localparam int CTRL_TIE  = 0;
    localparam int CTRL_PE   = 1;
    localparam int CTRL_WOM  = 2;
    localparam int CTRL_CPHA = 3;
    localparam int CTRL_CPOL = 4;
    localparam int CTRL_MST  = 5;
    localparam int CTRL_RIE  = 7;
    localparam logic [7:0] CTRL_WMASK = 8'hBF;
    localparam logic [7:0] RST_CTRL   = 8'h28;

    // Status and control register fields
    localparam int ST_BR_LO = 0;
    localparam int ST_BR_HI = 1;
    localparam int ST_MFE   = 2;
    localparam int ST_TEF   = 3;
    localparam int ST_MFF   = 4;
    localparam int ST_OVF   = 5;
    localparam int ST_EIE   = 6;
    localparam int ST_RXF   = 7;
    localparam logic [7:0] STAT_WMASK = 8'h47;
    localparam logic [7:0] RST_STAT   = 8'h08;

    // Half bit time in bus cycles for each baud select
    localparam logic [6:0] HALF_DIV2   = 7'h01;
    localparam logic [6:0] HALF_DIV8   = 7'h04;
    localparam logic [6:0] HALF_DIV32  = 7'h10;
    localparam logic [6:0] HALF_DIV128 = 7'h40;

    // Transfer counters
    localparam logic [3:0] LAST_EDGE = 4'hF;
    localparam logic [2:0] OVR_BIT   = 3'h1;

    // Synchronised pin lanes
    localparam int SYNC_W  = 4;
    localparam int SY_SCK  = 0;
    localparam int SY_SS   = 1;
    localparam int SY_MISO = 2;
    localparam int SY_MOSI = 3;

    typedef enum logic [1:0]
    {
        XF_IDLE  = 2'b01,
        XF_SHIFT = 2'b10
    } sirc_xfer_t;

    typedef struct packed
    {
        logic [7:0] ctrl;
        logic [7:0] stat;
        logic       rx_arm;
        logic       ov_arm;
        logic       mf_arm;
        logic [7:0] txbuf;
        logic [7:0] rxbuf;
        logic [7:0] sr;
        logic       ob;
        sirc_xfer_t xf;
        logic [3:0] hcnt;
        logic [2:0] scnt;
        logic       lost;
        logic [6:0] div;
        logic       sck_o;
        logic       sck_d;
        logic       ss_d;
        logic       ack;
        logic [7:0] rdata;
    } sirc_state_t;

    localparam sirc_state_t RST_STATE = '{ctrl: RST_CTRL, stat: RST_STAT, xf: XF_IDLE,
                                          ss_d: 1'b1, default: '0};

    typedef struct packed
    {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
    } sirc_sync_t;

endpackage

/* File: hw/sirc_sync.sv */
// Two flip-flop synchroniser for the serial pin inputs
`timescale 1ns/100ps
module sirc_sync
(
    input  wire logic     clk,
    input  wire logic     rst_n_b,
    sirc_sync_if.core     sy
);
    import sirc_pkg::*;

    sirc_sync_t c_r;
    sirc_sync_t c_nxt;

    always_comb
    begin
        c_nxt.s1 = sy.raw;
        c_nxt.s2 = c_r.s1;
    end

    always_ff @(posedge clk or negedge rst_n_b)
    begin
        if (!rst_n_b)
            c_r <= '0;
        else
            c_r <= c_nxt;
    end

    // Only the second stage is visible
    assign sy.sync = c_r.s2;

endmodule // sirc_sync

/* File: hw/sirc_sync_if.sv */
// Raw pin levels in, synchronised levels out
`timescale 1ns/100ps
interface sirc_sync_if;
    logic [sirc_pkg::SYNC_W-1:0] raw;
    logic [sirc_pkg::SYNC_W-1:0] sync;
    modport top  (output raw, input sync);
    modport core (input raw, output sync);
endinterface

/* File: hw/sirc_top.sv */
// Byte-wide SPI port: registers, shifter, flags, interrupts and pin control
`timescale 1ns/100ps

// Notes on behaviour
// - Transmit request whenever transmit-empty is set and its enable is 1.
// - Receive request from receive-full only with its enable and port enabled.
// - Overrun drives the error request when receive and error enables are 1.
// - Mode fault drives the error request with receive, error and fault enables.
// - Mode fault flag is never set while fault detection is disabled.
// - Receive-full sets when a finished byte enters the receive register.
// - Transmit-empty sets when a queued byte enters the shift register.
// - Data write clears transmit-empty; master sends it right after current transfer.
// - Status read with receive-full set, then data read, clears receive-full.
// - Slave with nothing queued resends the previous shift register contents.
// - Port disabled: transmit-empty set, transfer aborted, shifter cleared, pins released.
// - Control bits and receive, overrun, fault flags are kept when the port is disabled.
// - Master mode fault with detection enabled clears the port enable.
// - In wait the port runs, registers are closed, requests still wake.
// - In stop the port freezes; reset out of stop aborts everything.
// - Debug halt without break clear holds flags; pending two-step completes later.
// - Debug halt without break clear ignores data writes entirely.
// - Debug halt with break clear lets flags clear, and they stay cleared.
// - Slave output driven only as selected slave; otherwise released.
// - While enabled the port owns its serial pin directions.
// - Master shifts out on master-out while sampling master-in.
// - Wired-OR mode makes master-out open drain.
// - Unread receive byte at capture of bit 1 sets overrun; new byte dropped.
// - Master with fault detection sets mode fault while select is low.
module sirc_top
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    input  wire logic        debug_halt,
    input  wire logic        break_clear_enable,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe_b,
    input  wire logic        mosi_in,
    output logic             mosi_out,
    output logic             mosi_oe_b,
    input  wire logic        miso_in,
    output logic             miso_out,
    output logic             miso_oe_b,
    input  wire logic        ss_b_in,
    output logic             pins_owned,
    output logic             tx_irq,
    output logic             rx_irq,
    output logic             err_irq
);
    import sirc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers

    logic [1:0]  rs_r;
    logic        rst_sync_b;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rs_r <= 2'h0;
        else
            rs_r <= {rs_r[0], 1'b1};
    end

    assign rst_sync_b = rs_r[1];

    sirc_sync_if sy ();

    assign sy.raw[SY_SCK]  = sck_in;
    assign sy.raw[SY_SS]   = ss_b_in;
    assign sy.raw[SY_MISO] = miso_in;
    assign sy.raw[SY_MOSI] = mosi_in;

    sirc_sync u_sync
    (
        .clk     (clk),
        .rst_n_b (rst_sync_b),
        .sy      (sy)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    sirc_state_t c_r;
    sirc_state_t c_nxt;

    logic        sck_s;
    logic        ss_s;
    logic        din;
    logic        rd;
    logic        wr;
    logic        acc_ok;
    logic        clr_ok;
    logic        mst_run;
    logic        slv_on;
    logic        tick;
    logic        sck_chg;
    logic        edge_go;
    logic        load;
    logic        mf_m;
    logic        mf_s;
    logic [6:0]  half;

    assign sck_s = sy.sync[SY_SCK];
    assign ss_s  = sy.sync[SY_SS];

    always_comb
    begin
        c_nxt   = c_r;
        rd      = avs_read & ~c_r.ack;
        wr      = avs_write & ~c_r.ack & avs_byteenable[0];
        acc_ok  = ~wait_mode;
        clr_ok  = ~debug_halt | break_clear_enable;
        mst_run = c_r.ctrl[CTRL_PE] & c_r.ctrl[CTRL_MST];
        slv_on  = c_r.ctrl[CTRL_PE] & ~c_r.ctrl[CTRL_MST];
        din     = c_r.ctrl[CTRL_MST] ? sy.sync[SY_MISO] : sy.sync[SY_MOSI];
        sck_chg = sck_s != c_r.sck_d;
        tick    = 1'b0;
        load    = 1'b0;
        edge_go = 1'b0;
        mf_m    = mst_run & c_r.stat[ST_MFE] & ~ss_s;
        mf_s    = slv_on & c_r.stat[ST_MFE] & (c_r.xf == XF_SHIFT) & ss_s;

        // One wait state per access; answer lands on the following edge
        c_nxt.ack   = (avs_read | avs_write) & ~c_r.ack;
        c_nxt.sck_d = sck_s;
        c_nxt.ss_d  = ss_s;

        // Register reads; closed in wait mode, answer is zero
        if (rd)
        begin
            c_nxt.rdata = 8'h00;
            if (acc_ok)
            begin
                if (avs_address == ADDR_CTRL)
                    c_nxt.rdata = c_r.ctrl;
                else if (avs_address == ADDR_STAT)
                begin
                    c_nxt.rdata  = c_r.stat;
                    c_nxt.rx_arm = c_r.rx_arm | c_r.stat[ST_RXF];
                    c_nxt.ov_arm = c_r.ov_arm | c_r.stat[ST_OVF];
                    c_nxt.mf_arm = c_r.mf_arm | c_r.stat[ST_MFF];
                end
                else if (avs_address == ADDR_DATA)
                begin
                    c_nxt.rdata = c_r.rxbuf;
                    if (clr_ok)
                    begin
                        if (c_r.rx_arm)
                            c_nxt.stat[ST_RXF] = 1'b0;
                        if (c_r.ov_arm)
                            c_nxt.stat[ST_OVF] = 1'b0;
                        c_nxt.rx_arm = 1'b0;
                        c_nxt.ov_arm = 1'b0;
                    end
                end
            end
        end

        // Register writes
        if (wr && acc_ok)
        begin
            if (avs_address == ADDR_CTRL)
            begin
                c_nxt.ctrl = avs_writedata[7:0] & CTRL_WMASK;
                if (c_r.mf_arm && clr_ok && !(mf_m || mf_s))
                begin
                    c_nxt.stat[ST_MFF] = 1'b0;
                    c_nxt.mf_arm       = 1'b0;
                end
            end
            else if (avs_address == ADDR_STAT)
                c_nxt.stat = (c_r.stat & ~STAT_WMASK) | (avs_writedata[7:0] & STAT_WMASK);
            else if (avs_address == ADDR_DATA && clr_ok)
            begin
                c_nxt.txbuf        = avs_writedata[7:0];
                c_nxt.stat[ST_TEF] = 1'b0;
            end
        end

        // Master bit-rate divider, free running while the master is enabled
        case (c_r.stat[ST_BR_HI:ST_BR_LO])
            2'h0:    half = HALF_DIV2;
            2'h1:    half = HALF_DIV8;
            2'h2:    half = HALF_DIV32;
            default: half = HALF_DIV128;
        endcase
        if (mst_run)
        begin
            if (c_r.div >= half - 7'h01)
            begin
                c_nxt.div = 7'h00;
                tick      = 1'b1;
            end
            else
                c_nxt.div = c_r.div + 7'h01;
        end

        // Transfer start
        case (c_r.xf)
            XF_IDLE:
            begin
                if (mst_run && tick && !c_r.stat[ST_TEF])
                    load = 1'b1;
                else if (slv_on && !ss_s && !c_r.ctrl[CTRL_CPHA] && c_r.ss_d)
                    load = 1'b1;
                else if (slv_on && !ss_s && c_r.ctrl[CTRL_CPHA] && sck_chg
                         && sck_s != c_r.ctrl[CTRL_CPOL])
                begin
                    load    = 1'b1;
                    edge_go = 1'b1;
                end
            end
            XF_SHIFT:
            begin
                if (mst_run)
                    edge_go = tick;
                else
                    edge_go = slv_on & ~ss_s & sck_chg;
            end
            default:
                c_nxt.xf = XF_IDLE;
        endcase

        if (load)
        begin
            // Without a fresh byte the shifter keeps its last contents
            if (!c_r.stat[ST_TEF])
            begin
                c_nxt.sr           = c_r.txbuf;
                c_nxt.stat[ST_TEF] = 1'b1;
            end
            c_nxt.ob   = c_nxt.sr[7];
            c_nxt.xf   = XF_SHIFT;
            c_nxt.hcnt = 4'h0;
            c_nxt.scnt = 3'h0;
            c_nxt.lost = 1'b0;
        end

        // One serial clock edge: sample on one parity, drive on the other
        if (edge_go)
        begin
            if (c_nxt.hcnt[0] == c_r.ctrl[CTRL_CPHA])
            begin
                if (c_nxt.scnt == OVR_BIT && c_nxt.stat[ST_RXF])
                begin
                    c_nxt.stat[ST_OVF] = 1'b1;
                    c_nxt.lost         = 1'b1;
                end
                c_nxt.sr   = {c_nxt.sr[6:0], din};
                c_nxt.scnt = c_nxt.scnt + 3'h1;
            end
            else
                c_nxt.ob = c_nxt.sr[7];
            if (c_r.ctrl[CTRL_MST])
                c_nxt.sck_o = ~c_nxt.sck_o;
            if (c_nxt.hcnt == LAST_EDGE)
            begin
                c_nxt.xf = XF_IDLE;
                if (!c_nxt.lost)
                begin
                    c_nxt.rxbuf        = c_nxt.sr;
                    c_nxt.stat[ST_RXF] = 1'b1;
                end
                c_nxt.lost = 1'b0;
            end
            else
                c_nxt.hcnt = c_nxt.hcnt + 4'h1;
        end

        // Mode faults; a deselected slave abandons its byte
        if (mf_m || mf_s)
            c_nxt.stat[ST_MFF] = 1'b1;
        if (mf_m)
            c_nxt.ctrl[CTRL_PE] = 1'b0;
        if (slv_on && ss_s && c_r.xf == XF_SHIFT)
            c_nxt.xf = XF_IDLE;

        // Partial reset while disabled; receive, overrun, fault flags and control bits survive
        if (!c_nxt.ctrl[CTRL_PE])
        begin
            c_nxt.stat[ST_TEF] = 1'b1;
            c_nxt.xf           = XF_IDLE;
            c_nxt.sr           = 8'h00;
            c_nxt.hcnt         = 4'h0;
            c_nxt.scnt         = 3'h0;
            c_nxt.lost         = 1'b0;
            c_nxt.div          = 7'h00;
        end
        if (c_nxt.xf == XF_IDLE)
            c_nxt.sck_o = c_nxt.ctrl[CTRL_CPOL];

        // Stop freezes everything, bus answer included
        if (stop_mode)
            c_nxt = c_r;
    end

    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            c_r <= RST_STATE;
        else
            c_r <= c_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign avs_waitrequest = (avs_read | avs_write) & ~c_r.ack;
    assign avs_readdata    = {24'h00_0000, c_r.rdata};

    // Requests are plain levels so they also wake the core from wait
    assign tx_irq  = c_r.stat[ST_TEF] & c_r.ctrl[CTRL_TIE];
    assign rx_irq  = c_r.stat[ST_RXF] & c_r.ctrl[CTRL_RIE] & c_r.ctrl[CTRL_PE];
    assign err_irq = c_r.ctrl[CTRL_RIE] & c_r.stat[ST_EIE]
                   & (c_r.stat[ST_OVF]
                   | (c_r.stat[ST_MFF] & c_r.stat[ST_MFE]));

    // Open drain pins only ever pull low
    assign pins_owned = c_r.ctrl[CTRL_PE];
    assign sck_out    = c_r.sck_o;
    assign sck_oe_b   = ~mst_run | (c_r.ctrl[CTRL_WOM] & c_r.sck_o);
    assign mosi_out   = c_r.ob;
    assign mosi_oe_b  = ~mst_run | (c_r.ctrl[CTRL_WOM] & c_r.ob);
    assign miso_out   = c_r.ob;
    assign miso_oe_b  = ~(slv_on & ~ss_s) | (c_r.ctrl[CTRL_WOM] & c_r.ob);

endmodule // sirc_top

/* File: tb/sirc_spi_peer.sv */
// Behavioural SPI slave standing at the far end of the master link
`timescale 1ns/100ps
module sirc_spi_peer
(
    input  wire logic       rst_b,
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic [7:0] sh = 8'h00;
    logic [3:0] nbits = 4'h0;
    initial
    begin
        miso    = 1'b0;
        rx_byte = 8'h00;
    end
    ////////////////////////////////////////////////////////////////
    // Leading edge presents the next bit, MSB first
    always @(posedge sck)
    begin
        if (rst_b && nbits == 4'h0)
            sh = tx_byte;
        miso <= sh[7];
        sh = {sh[6:0], 1'b0};
    end
    // Trailing edge captures; a finished frame leaves the inverse on the line
    always @(negedge sck or negedge rst_b)
    begin
        if (!rst_b)
            nbits <= 4'h0;
        else
        begin
            rx_byte <= {rx_byte[6:0], mosi};
            nbits   <= (nbits == 4'h7) ? 4'h0 : nbits + 4'h1;
            if (nbits == 4'h7)
                miso <= ~miso;
        end
    end
endmodule // sirc_spi_peer

/* File: tb/sirc_tb_top.sv */
// Self-checking bench for the SPI port
`timescale 1ns/100ps
module sirc_tb_top;
    import sirc_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        wait_mode = 1'b0;
    logic        stop_mode = 1'b0;
    logic        debug_halt = 1'b0;
    logic        break_clear_enable = 1'b0;
    logic        sck_in = 1'b0;
    logic        mosi_in = 1'b0;
    logic        ss_b_in = 1'b1;
    logic        miso_in;
    logic        sck_out, sck_oe_b, mosi_out, mosi_oe_b, miso_out, miso_oe_b;
    logic        pins_owned, tx_irq, rx_irq, err_irq;
    logic [7:0]  peer_tx = 8'h3C;
    logic [7:0]  peer_rx;
    logic [7:0]  q;
    int          n_fail = 0;
    int          n_checks = 0;

    sirc_top i_dut (.*);
    sirc_spi_peer i_peer (.rst_b(rst_b), .sck(sck_out), .mosi(mosi_out), .tx_byte(peer_tx),
                          .miso(miso_in), .rx_byte(peer_rx));
    always #2 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic tmo;
        n_fail++;
        $display("[FAIL] wait expected answer seen timeout");
        conclude();
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
        begin
            n++;
            if (n > 300)
                tmo();
            @(posedge clk);
        end
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic poll(input int b, input logic v);
        int n;
        n = 0;
        q = {8{!v}};
        while (q[b] !== v)
        begin
            bus(1'b0, ADDR_STAT, 8'h00);
            n++;
            if (n > 600)
                tmo();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        bus(1'b0, ADDR_CTRL, 8'h00);
        chk("ctrl", q, RST_CTRL);
        bus(1'b0, ADDR_STAT, 8'h00);
        chk("stat", q, RST_STAT);
        bus(1'b0, 4'hC, 8'h00);
        chk("unmapped", q, 8'h00);
        chk("irqs", {tx_irq, rx_irq, err_irq}, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_master;
        bus(1'b1, ADDR_STAT, 8'h42);
        bus(1'b1, ADDR_CTRL, 8'hAB);
        chk("tx_irq", tx_irq, 1'b1);
        bus(1'b1, ADDR_DATA, 8'hA5);
        poll(ST_TEF, 1'b1);
        bus(1'b1, ADDR_DATA, 8'h5A);
        bus(1'b0, ADDR_STAT, 8'h00);
        chk("tx queued", {q[ST_TEF], tx_irq}, 8'h00);
        poll(ST_RXF, 1'b1);
        chk("rx_irq", rx_irq, 1'b1);
        chk("peer byte", peer_rx, 8'hA5);
        poll(ST_OVF, 1'b1);
        chk("err_irq", err_irq, 1'b1);
        repeat (300) @(posedge clk);
        chk("peer byte 2", peer_rx, 8'h5A);
        bus(1'b0, ADDR_DATA, 8'h00);
        chk("old byte", q, 8'h3C);
        bus(1'b0, ADDR_STAT, 8'h00);
        chk("flags", q & 8'hA8, 8'h08);
        chk("irqs low", {rx_irq, err_irq}, 8'h00);
        $display("test master done");
    endtask
    task automatic t_disable;
        bus(1'b1, ADDR_DATA, 8'h11);
        poll(ST_RXF, 1'b1);
        bus(1'b1, ADDR_CTRL, 8'hA9);
        chk("pins", {pins_owned, mosi_oe_b, sck_oe_b, rx_irq}, 8'h06);
        bus(1'b0, ADDR_CTRL, 8'h00);
        chk("ctrl kept", q, 8'hA9);
        bus(1'b0, ADDR_STAT, 8'h00);
        chk("stat kept", q, 8'hCA);
        bus(1'b0, ADDR_DATA, 8'h00);
        chk("rx byte", q, 8'h3C);
        $display("test disable done");
    endtask
    task automatic t_fault;
        bus(1'b1, ADDR_CTRL, 8'hAF);
        ss_b_in <= 1'b0;
        repeat (10) @(posedge clk);
        bus(1'b0, ADDR_STAT, 8'h00);
        chk("no fault", {q[ST_MFF], pins_owned}, 8'h01);
        chk("open drain", mosi_oe_b, mosi_out);
        bus(1'b1, ADDR_STAT, 8'h46);
        poll(ST_MFF, 1'b1);
        chk("fault irq", {err_irq, pins_owned}, 8'h02);
        bus(1'b0, ADDR_CTRL, 8'h00);
        chk("fault off", q, 8'hAD);
        ss_b_in <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b1, ADDR_CTRL, 8'hA9);
        bus(1'b1, ADDR_STAT, 8'h42);
        bus(1'b0, ADDR_STAT, 8'h00);
        chk("fault clear", q, 8'h4A);
        $display("test fault done");
    endtask
    task automatic t_halt;
        bus(1'b1, ADDR_CTRL, 8'hAB);
        bus(1'b1, ADDR_DATA, 8'h66);
        poll(ST_RXF, 1'b1);
        debug_halt <= 1'b1;
        bus(1'b1, ADDR_DATA, 8'h77);
        bus(1'b0, ADDR_STAT, 8'h00);
        chk("halt write", q, 8'hCA);
        bus(1'b0, ADDR_DATA, 8'h00);
        bus(1'b0, ADDR_STAT, 8'h00);
        chk("halt hold", q, 8'hCA);
        debug_halt <= 1'b0;
        bus(1'b0, ADDR_DATA, 8'h00);
        bus(1'b0, ADDR_STAT, 8'h00);
        chk("after halt", q, 8'h4A);
        bus(1'b1, ADDR_DATA, 8'h55);
        poll(ST_RXF, 1'b1);
        debug_halt         <= 1'b1;
        break_clear_enable <= 1'b1;
        bus(1'b0, ADDR_DATA, 8'h00);
        debug_halt         <= 1'b0;
        break_clear_enable <= 1'b0;
        bus(1'b0, ADDR_STAT, 8'h00);
        chk("halt clear", q, 8'h4A);
        $display("test halt done");
    endtask
    task automatic t_lowpower;
        wait_mode <= 1'b1;
        bus(1'b0, ADDR_CTRL, 8'h00);
        chk("wait read", q, 8'h00);
        bus(1'b1, ADDR_CTRL, 8'h00);
        wait_mode <= 1'b0;
        bus(1'b0, ADDR_CTRL, 8'h00);
        chk("wait write", q, 8'hAB);
        bus(1'b1, ADDR_DATA, 8'h99);
        repeat (60) @(posedge clk);
        stop_mode <= 1'b1;
        repeat (200) @(posedge clk);
        stop_mode <= 1'b0;
        poll(ST_RXF, 1'b1);
        bus(1'b0, ADDR_DATA, 8'h00);
        chk("resumed", q, 8'h3C);
        bus(1'b1, ADDR_DATA, 8'h99);
        repeat (60) @(posedge clk);
        stop_mode <= 1'b1;
        rst_b     <= 1'b0;
        repeat (4) @(posedge clk);
        stop_mode <= 1'b0;
        rst_b     <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, ADDR_CTRL, 8'h00);
        chk("stop reset", {q[6:0], pins_owned}, {RST_CTRL[6:0], 1'b0});
        $display("test lowpower done");
    endtask
    // Link clock of 160 ns, still between frames
    task automatic slave_frame(input logic [7:0] pat, output logic [7:0] got);
        for (int i = 7; i >= 0; i--)
        begin
            sck_in  <= 1'b1;
            mosi_in <= pat[i];
            repeat (20) @(posedge clk);
            got[i] = miso_out;
            sck_in  <= 1'b0;
            repeat (20) @(posedge clk);
        end
        mosi_in <= ~pat[0];
    endtask
    task automatic t_slave;
        bus(1'b1, ADDR_CTRL, 8'h8A);
        chk("deselected", miso_oe_b, 1'b1);
        ss_b_in <= 1'b0;
        repeat (6) @(posedge clk);
        chk("selected", miso_oe_b, 1'b0);
        slave_frame(8'h96, q);
        poll(ST_RXF, 1'b1);
        bus(1'b0, ADDR_DATA, 8'h00);
        chk("slave rx", q, 8'h96);
        slave_frame(8'h4B, q);
        chk("resend", q, 8'h96);
        ss_b_in <= 1'b1;
        repeat (6) @(posedge clk);
        chk("released", miso_oe_b, 1'b1);
        $display("test slave done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_master();
        t_disable();
        t_fault();
        t_halt();
        t_lowpower();
        t_slave();
        conclude();
    end
endmodule // sirc_tb_top

/* File: tb/sirc_top_monitor.sv */
// Port-level checker for the SPI port, bound to the top module
`timescale 1ns/100ps
module sirc_top_monitor
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        wait_mode,
    input wire logic        stop_mode,
    input wire logic        debug_halt,
    input wire logic        break_clear_enable,
    input wire logic        ss_b_in,
    input wire logic        sck_out,
    input wire logic        mosi_out,
    input wire logic        sck_oe_b,
    input wire logic        mosi_oe_b,
    input wire logic        miso_oe_b,
    input wire logic        pins_owned,
    input wire logic        tx_irq,
    input wire logic        rx_irq,
    input wire logic        err_irq
);
    import sirc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////
    property p_bus_answer;
        (avs_read || avs_write) && avs_waitrequest && !stop_mode |=> !avs_waitrequest || stop_mode;
    endproperty
    property p_wait_zero;
        avs_read && !avs_waitrequest && $past(wait_mode) |-> avs_readdata == 32'h0000_0000;
    endproperty
    property p_release;
        !pins_owned |-> mosi_oe_b && miso_oe_b && sck_oe_b;
    endproperty
    property p_slave_hiz;
        ss_b_in [*4] |-> miso_oe_b;
    endproperty
    property p_rx_enabled;
        rx_irq |-> pins_owned;
    endproperty
    // Writes may legally drop an enable, so only quiet halt cycles count
    property p_halt_hold;
        debug_halt && !break_clear_enable && $past(debug_halt && !break_clear_enable)
            && !$past(avs_write) |-> !$fell(err_irq) && !$fell(rx_irq);
    endproperty
    property p_halt_write;
        debug_halt && !break_clear_enable && avs_write && avs_waitrequest
            && avs_address == ADDR_DATA |-> ##1 !$fell(tx_irq) ##1 !$fell(tx_irq);
    endproperty
    property p_stop_freeze;
        stop_mode && $past(stop_mode) |-> $stable(sck_out) && $stable(mosi_out) && $stable(tx_irq);
    endproperty
    property p_tx_clear;
        avs_write && avs_waitrequest && avs_address == ADDR_DATA && tx_irq && pins_owned
            && !debug_halt && !wait_mode && !stop_mode |=> !tx_irq;
    endproperty
    ////////////////////////////////////////////////////////////////
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
    a_wait_zero: assert property (p_wait_zero) else $error("wait read not zero");
    a_release: assert property (p_release) else $error("pins driven while off");
    a_slave_hiz: assert property (p_slave_hiz) else $error("slave out not released");
    a_rx_enabled: assert property (p_rx_enabled) else $error("rx irq while off");
    a_halt_hold: assert property (p_halt_hold) else $error("flag cleared in halt");
    a_halt_write: assert property (p_halt_write) else $error("halt write acted");
    a_stop_freeze: assert property (p_stop_freeze) else $error("moved in stop");
    a_tx_clear: assert property (p_tx_clear) else $error("tx empty not cleared");
    c_rx: cover property ($rose(rx_irq));
    c_err: cover property ($rose(err_irq));
    c_off: cover property ($fell(pins_owned));
endmodule // sirc_top_monitor

bind sirc_top sirc_top_monitor i_mon (.*);
